// >>> hdl/rhp_pkg.sv
// Purpose: Shared constants and types for the radio host pin block
// Assumes: 32-bit Avalon-MM register bus, byte addresses
// Notes: One word per register, low bits used, upper bits read zero
package rhp_pkg;
    typedef enum logic [1:0] {RHP_BASE, RHP_REMOTE, RHP_ROUTER, RHP_SPARE} rhp_role_t;

    localparam int RHP_NPORT = 6;
    localparam int RHP_AW = 8;

    // Register byte offsets
    localparam logic [7:0] RHP_CTRL = 8'h00;
    localparam logic [7:0] RHP_PULSE = 8'h04;
    localparam logic [7:0] RHP_TMO = 8'h08;
    localparam logic [7:0] RHP_DIR = 8'h0C;
    localparam logic [7:0] RHP_LVL = 8'h10;
    localparam logic [7:0] RHP_PULL = 8'h14;
    localparam logic [7:0] RHP_WAKE = 8'h18;
    localparam logic [7:0] RHP_SDIR = 8'h1C;
    localparam logic [7:0] RHP_SLVL = 8'h20;
    localparam logic [7:0] RHP_SPULL = 8'h24;
    localparam logic [7:0] RHP_PINS = 8'h28;
    localparam logic [7:0] RHP_ISTAT = 8'h2C;
    localparam logic [7:0] RHP_IMASK = 8'h30;
    localparam logic [7:0] RHP_STAT = 8'h34;

    // Control fields
    localparam int RHP_C_ROLE = 0;
    localparam int RHP_C_ACT_ALT = 2;
    localparam int RHP_C_LNK_ALT = 3;
    localparam int RHP_C_FC_ALT = 4;

    // Interrupt status fields
    localparam int RHP_I_ACT = 0;
    localparam int RHP_I_UP = 1;
    localparam int RHP_I_DOWN = 2;
    localparam int RHP_I_WAKE = 3;
    localparam int RHP_NIRQ = 4;

    // Status fields
    localparam int RHP_S_LINK = 0;
    localparam int RHP_S_CTS = 1;
    localparam int RHP_S_TXOK = 2;
    localparam int RHP_S_SLEEP = 3;

    // Flow control ports
    localparam int RHP_P_CTS = 4;
    localparam int RHP_P_RTS = 5;

    // Reset values and counts
    localparam logic [5:0] RHP_CTRL_RST = 6'h01;
    localparam logic [15:0] RHP_PULSE_RST = 16'h0100;
    localparam logic [31:0] RHP_TMO_RST = 32'h00100000;
    localparam logic [5:0] RHP_DIR_RST = 6'h00;
    localparam logic [5:0] RHP_LVL_RST = 6'h00;
    localparam logic [5:0] RHP_PULL_RST = 6'h3F;
    localparam logic [5:0] RHP_SDIR_RST = 6'h00;
    localparam logic [5:0] RHP_SLVL_RST = 6'h00;
    localparam logic [5:0] RHP_SPULL_RST = 6'h3F;
    localparam logic [5:0] RHP_MISS_LIMIT = 6'd50;
endpackage : rhp_pkg

// >>> hdl/rhp_io_if.sv
// Purpose: Settings and sampled pins between control and port logic
// Assumes: Single clock domain
// Notes: cfg side owns settings, io side returns pin state
`timescale 1ns/100ps
`default_nettype none
interface rhp_io_if #(parameter int N = 6);
    logic [N-1:0] dir;
    logic [N-1:0] lvl;
    logic [N-1:0] pull;
    logic [N-1:0] wake_en;
    logic [N-1:0] sdir;
    logic [N-1:0] slvl;
    logic [N-1:0] spull;
    logic sleep;
    logic fc_alt;
    logic cts_n;
    logic [N-1:0] pin_sync;
    logic wake_evt;
    modport cfg (
        output dir, lvl, pull, wake_en, sdir, slvl, spull, sleep, fc_alt, cts_n,
        input pin_sync, wake_evt
    );
    modport io (
        input dir, lvl, pull, wake_en, sdir, slvl, spull, sleep, fc_alt, cts_n,
        output pin_sync, wake_evt
    );
endinterface : rhp_io_if
`default_nettype wire

// >>> hdl/rhp_ports.sv
// Purpose: Configurable I/O port cells with sleep settings and wake
// Assumes: Pin inputs are asynchronous and are synchronised here
// Notes: Port outputs, enables and pull-ups are registered
`timescale 1ns/100ps
`default_nettype none
module rhp_ports #(parameter int N = 6) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Settings
    rhp_io_if.io cfg,
    // Pins
    input wire logic [N-1:0] pin_in,
    output logic [N-1:0] pin_out,
    output logic [N-1:0] pin_oe,
    output logic [N-1:0] pin_pull
);
    import rhp_pkg::*;

    logic [N-1:0] meta_q;
    logic [N-1:0] sync_q;
    logic [N-1:0] prev_q;
    logic [N-1:0] wake_hit;
    logic wake_q;

    genvar i;
    generate
        for (i = 0; i < N; i++)
        begin : g_port
            logic eff_dir;
            logic eff_lvl;
            logic eff_pull;
            // Same options on every port, plus flow control on ports four and five; sleep swaps in its own set
            assign eff_dir = cfg.sleep ? cfg.sdir[i] : cfg.dir[i];
            assign eff_lvl = cfg.sleep ? cfg.slvl[i] : cfg.lvl[i];
            assign eff_pull = cfg.sleep ? cfg.spull[i] : cfg.pull[i];

            always_ff @(posedge clock)
            begin
                if (!rst_n)
                begin
                    meta_q[i] <= 1'b1;
                    sync_q[i] <= 1'b1;
                    prev_q[i] <= 1'b1;
                end
                else
                begin
                    meta_q[i] <= pin_in[i];
                    sync_q[i] <= meta_q[i];
                    prev_q[i] <= sync_q[i];
                end
            end

            always_ff @(posedge clock)
            begin
                if (!rst_n)
                begin
                    pin_oe[i] <= RHP_DIR_RST[i];
                    pin_out[i] <= RHP_LVL_RST[i];
                    pin_pull[i] <= RHP_PULL_RST[i];
                end
                else if (cfg.fc_alt && i == RHP_P_CTS)
                begin
                    pin_oe[i] <= 1'b1;
                    pin_out[i] <= cfg.cts_n;
                    pin_pull[i] <= 1'b0;
                end
                else if (cfg.fc_alt && i == RHP_P_RTS)
                begin
                    pin_oe[i] <= 1'b0;
                    pin_out[i] <= 1'b0;
                    pin_pull[i] <= eff_pull;
                end
                else
                begin
                    pin_oe[i] <= eff_dir;
                    pin_out[i] <= eff_lvl;
                    pin_pull[i] <= ~eff_dir & eff_pull;
                end
            end

            // Wake on any change of a wake-enabled input port while asleep
            assign wake_hit[i] = cfg.sleep & ~eff_dir & cfg.wake_en[i]
                & (sync_q[i] ^ prev_q[i]);
        end
    endgenerate

    always_ff @(posedge clock)
    begin
        if (!rst_n)
            wake_q <= 1'b0;
        else
            wake_q <= |wake_hit;
    end

    assign cfg.pin_sync = sync_q;
    assign cfg.wake_evt = wake_q;
endmodule : rhp_ports
`default_nettype wire

// >>> hdl/rhp_pin_status.sv
// Purpose: Activity, link detect, configurable ports and flow control
// Assumes: Radio core events are one-cycle pulses on this clock
// Notes: Registers on Avalon-MM, one wait cycle per access
// Operation
// - Base: pulse activity on valid receive
// - Remote: pulse activity on each transmit
// - Router: pulse on upstream receive, downstream transmit
// - Activity pin may carry diagnostic serial out
// - Base: link on packet, drop after timeout
// - Router/remote: link on sync, drop 50 misses
// - Link pin may become diagnostic serial in
// - Input ports: pull-up and wake from sleep
// - Output ports drive configured level from reset
// - Sleep uses separate direction, pull, level
// - Ports one and two match port zero
// - Ports four, five alternate as flow control
// - Clear-to-send low only while accepting data
// - Halt transmit while request-to-send high
`timescale 1ns/100ps
`default_nettype none
module rhp_pin_status #(
    parameter logic [15:0] PULSE_RST = rhp_pkg::RHP_PULSE_RST,
    parameter logic [31:0] TMO_RST = rhp_pkg::RHP_TMO_RST
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Avalon-MM slave
    input wire logic [rhp_pkg::RHP_AW-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic irq,
    // Radio core events
    input wire logic rx_valid,
    input wire logic rx_upstream,
    input wire logic tx_done,
    input wire logic tx_downstream,
    input wire logic hop_sync_gain,
    input wire logic hop_tick,
    input wire logic beacon_heard,
    input wire logic sleep_mode,
    input wire logic host_rx_ready,
    input wire logic diagnostic_serial_out_data,
    // Core status returns
    output logic diagnostic_serial_in,
    output logic host_tx_allow,
    output logic wake_req,
    // Indicator pins
    output logic activity_indicator,
    input wire logic link_pin_in,
    output logic link_detect_n,
    output logic link_pin_oe,
    // Configurable port pins
    input wire logic [rhp_pkg::RHP_NPORT-1:0] io_pin_in,
    output logic [rhp_pkg::RHP_NPORT-1:0] io_pin_out,
    output logic [rhp_pkg::RHP_NPORT-1:0] io_pin_oe,
    output logic [rhp_pkg::RHP_NPORT-1:0] io_pull_en
);
    import rhp_pkg::*;

    localparam int N = RHP_NPORT;

    rhp_io_if #(.N(N)) io_bus ();

    logic [5:0] ctrl_q;
    logic [15:0] pulse_len_q;
    logic [31:0] tmo_q;
    logic [N-1:0] dir_q;
    logic [N-1:0] lvl_q;
    logic [N-1:0] pull_q;
    logic [N-1:0] wake_q;
    logic [N-1:0] sdir_q;
    logic [N-1:0] slvl_q;
    logic [N-1:0] spull_q;
    logic [RHP_NIRQ-1:0] istat_q;
    logic [RHP_NIRQ-1:0] imask_q;
    logic [RHP_NIRQ-1:0] clr_q;
    logic [RHP_NIRQ-1:0] evt;

    rhp_role_t role;
    logic act_alt;
    logic lnk_alt;
    logic fc_alt;

    logic wr_en;
    logic rd_take;
    logic [31:0] rd_d;
    logic [31:0] wr_m;

    logic act_evt;
    logic [15:0] act_cnt_q;
    logic link_q;
    logic link_d;
    logic [31:0] tmo_cnt_q;
    logic [5:0] miss_q;
    logic beacon_seen_q;
    logic link_meta_q;
    logic link_sync_q;
    logic cts_n_q;
    logic sleep_q;

    assign role = rhp_role_t'(ctrl_q[RHP_C_ROLE +: 2]);
    assign act_alt = ctrl_q[RHP_C_ACT_ALT];
    assign lnk_alt = ctrl_q[RHP_C_LNK_ALT];
    assign fc_alt = ctrl_q[RHP_C_FC_ALT];

    // Write data merged under byte enables
    always_comb
    begin
        wr_m = rd_d;
        for (int b = 0; b < 4; b++)
        begin
            if (avs_byteenable[b])
                wr_m[b*8 +: 8] = avs_writedata[b*8 +: 8];
        end
    end

    // Bus handshake: waitrequest drops for one cycle per request
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            avs_waitrequest <= 1'b1;
        else if ((avs_read || avs_write) && avs_waitrequest)
            avs_waitrequest <= 1'b0;
        else
            avs_waitrequest <= 1'b1;
    end

    assign wr_en = avs_write && !avs_waitrequest;
    assign rd_take = avs_read && avs_waitrequest;

    always_comb
    begin
        rd_d = 32'h00000000;
        unique case (avs_address)
            RHP_CTRL: rd_d[5:0] = ctrl_q;
            RHP_PULSE: rd_d[15:0] = pulse_len_q;
            RHP_TMO: rd_d = tmo_q;
            RHP_DIR: rd_d[N-1:0] = dir_q;
            RHP_LVL: rd_d[N-1:0] = lvl_q;
            RHP_PULL: rd_d[N-1:0] = pull_q;
            RHP_WAKE: rd_d[N-1:0] = wake_q;
            RHP_SDIR: rd_d[N-1:0] = sdir_q;
            RHP_SLVL: rd_d[N-1:0] = slvl_q;
            RHP_SPULL: rd_d[N-1:0] = spull_q;
            RHP_PINS: rd_d[N-1:0] = io_bus.pin_sync;
            RHP_ISTAT: rd_d[RHP_NIRQ-1:0] = istat_q;
            RHP_IMASK: rd_d[RHP_NIRQ-1:0] = imask_q;
            RHP_STAT:
            begin
                rd_d[RHP_S_LINK] = link_q;
                rd_d[RHP_S_CTS] = cts_n_q;
                rd_d[RHP_S_TXOK] = host_tx_allow;
                rd_d[RHP_S_SLEEP] = sleep_q;
            end
            default: ;
        endcase
    end

    // Read data captured at the edge that drops waitrequest
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            avs_readdata <= 32'h00000000;
            clr_q <= '0;
        end
        else if (rd_take)
        begin
            avs_readdata <= rd_d;
            clr_q <= (avs_address == RHP_ISTAT) ? istat_q : '0;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            ctrl_q <= RHP_CTRL_RST;
            pulse_len_q <= PULSE_RST;
            tmo_q <= TMO_RST;
            dir_q <= RHP_DIR_RST;
            lvl_q <= RHP_LVL_RST;
            pull_q <= RHP_PULL_RST;
            wake_q <= '0;
            sdir_q <= RHP_SDIR_RST;
            slvl_q <= RHP_SLVL_RST;
            spull_q <= RHP_SPULL_RST;
            imask_q <= '0;
        end
        else if (wr_en)
        begin
            unique case (avs_address)
                RHP_CTRL: ctrl_q <= wr_m[5:0];
                RHP_PULSE: pulse_len_q <= wr_m[15:0];
                RHP_TMO: tmo_q <= wr_m;
                RHP_DIR: dir_q <= wr_m[N-1:0];
                RHP_LVL: lvl_q <= wr_m[N-1:0];
                RHP_PULL: pull_q <= wr_m[N-1:0];
                RHP_WAKE: wake_q <= wr_m[N-1:0];
                RHP_SDIR: sdir_q <= wr_m[N-1:0];
                RHP_SLVL: slvl_q <= wr_m[N-1:0];
                RHP_SPULL: spull_q <= wr_m[N-1:0];
                RHP_IMASK: imask_q <= wr_m[RHP_NIRQ-1:0];
                default: ;
            endcase
        end
    end

    always_comb
    begin
        unique case (role)
            RHP_BASE: act_evt = rx_valid;
            RHP_ROUTER: act_evt = (rx_valid & rx_upstream)
                | (tx_done & tx_downstream);
            default: act_evt = tx_done;
        endcase
    end

    // Pulse stretcher, reloaded by every new event
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            act_cnt_q <= 16'h0000;
        else if (act_evt)
            act_cnt_q <= pulse_len_q;
        else if (act_cnt_q != 16'h0000)
            act_cnt_q <= act_cnt_q - 16'h0001;
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
            activity_indicator <= 1'b0;
        else if (act_alt)
            activity_indicator <= diagnostic_serial_out_data;
        else
            activity_indicator <= act_evt ? (pulse_len_q != 16'h0000)
                : (act_cnt_q > 16'h0001);
    end

    // Base: registration time-out since the last valid packet
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            tmo_cnt_q <= 32'h00000000;
        else if (rx_valid)
            tmo_cnt_q <= tmo_q;
        else if (tmo_cnt_q != 32'h00000000)
            tmo_cnt_q <= tmo_cnt_q - 32'h00000001;
    end

    // Router/remote: consecutive hops without a beacon
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            miss_q <= 6'h00;
            beacon_seen_q <= 1'b0;
        end
        else if (hop_sync_gain)
        begin
            miss_q <= 6'h00;
            beacon_seen_q <= 1'b0;
        end
        else if (hop_tick)
        begin
            if (beacon_seen_q || beacon_heard)
                miss_q <= 6'h00;
            else if (miss_q != RHP_MISS_LIMIT)
                miss_q <= miss_q + 6'h01;
            beacon_seen_q <= 1'b0;
        end
        else if (beacon_heard)
            beacon_seen_q <= 1'b1;
    end

    always_comb
    begin
        link_d = link_q;
        if (role == RHP_BASE)
        begin
            if (rx_valid)
                link_d = 1'b1;
            else if (tmo_cnt_q == 32'h00000001)
                link_d = 1'b0;
        end
        else
        begin
            if (hop_sync_gain)
                link_d = 1'b1;
            else if (hop_tick && !beacon_seen_q && !beacon_heard
                && miss_q == RHP_MISS_LIMIT - 6'h01)
                link_d = 1'b0;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
            link_q <= 1'b0;
        else
            link_q <= link_d;
    end

    // Link pin: output by default, diagnostic input when alternate
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            link_detect_n <= 1'b1;
            link_pin_oe <= 1'b1;
        end
        else
        begin
            link_detect_n <= ~link_d;
            link_pin_oe <= ~lnk_alt;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            link_meta_q <= 1'b1;
            link_sync_q <= 1'b1;
            diagnostic_serial_in <= 1'b1;
        end
        else
        begin
            link_meta_q <= link_pin_in;
            link_sync_q <= link_meta_q;
            diagnostic_serial_in <= lnk_alt ? link_sync_q : 1'b1;
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            cts_n_q <= 1'b1;
            host_tx_allow <= 1'b1;
        end
        else
        begin
            cts_n_q <= ~host_rx_ready;
            host_tx_allow <= ~fc_alt | ~io_bus.pin_sync[RHP_P_RTS];
        end
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            sleep_q <= 1'b0;
            wake_req <= 1'b0;
        end
        else
        begin
            sleep_q <= sleep_mode;
            wake_req <= io_bus.wake_evt;
        end
    end

    assign io_bus.dir = dir_q;
    assign io_bus.lvl = lvl_q;
    assign io_bus.pull = pull_q;
    assign io_bus.wake_en = wake_q;
    assign io_bus.sdir = sdir_q;
    assign io_bus.slvl = slvl_q;
    assign io_bus.spull = spull_q;
    assign io_bus.sleep = sleep_q;
    assign io_bus.fc_alt = fc_alt;
    assign io_bus.cts_n = cts_n_q;

    rhp_ports #(.N(N)) u_ports (
        .clock(clock),
        .rst_n(rst_n),
        .cfg(io_bus.io),
        .pin_in(io_pin_in),
        .pin_out(io_pin_out),
        .pin_oe(io_pin_oe),
        .pin_pull(io_pull_en)
    );

    // Sticky interrupt status; a new event wins over a read clear
    assign evt[RHP_I_ACT] = act_evt;
    assign evt[RHP_I_UP] = link_d & ~link_q;
    assign evt[RHP_I_DOWN] = ~link_d & link_q;
    assign evt[RHP_I_WAKE] = io_bus.wake_evt;

    always_ff @(posedge clock)
    begin
        if (!rst_n)
            istat_q <= '0;
        else if (avs_read && !avs_waitrequest)
            istat_q <= (istat_q & ~clr_q) | evt;
        else
            istat_q <= istat_q | evt;
    end

    always_ff @(posedge clock)
    begin
        if (!rst_n)
            irq <= 1'b0;
        else
            irq <= |(istat_q & imask_q);
    end
endmodule : rhp_pin_status
`default_nettype wire

// >>> testbench/rhp_pin_status_checker.sv
// Purpose: Port level assertions for the radio host pin block
// Assumes: Control tracked from bus writes
// Notes: Bound into the block
`timescale 1ns/100ps
`default_nettype none
module rhp_pin_status_checker (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Register bus
    input wire logic [rhp_pkg::RHP_AW-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic avs_waitrequest,
    // Core side
    input wire logic rx_valid,
    input wire logic rx_upstream,
    input wire logic tx_done,
    input wire logic tx_downstream,
    input wire logic hop_sync_gain,
    input wire logic host_rx_ready,
    input wire logic diagnostic_serial_out_data,
    input wire logic sleep_mode,
    input wire logic host_tx_allow,
    // Pins
    input wire logic activity_indicator,
    input wire logic link_detect_n,
    input wire logic link_pin_oe,
    input wire logic [rhp_pkg::RHP_NPORT-1:0] io_pin_in,
    input wire logic [rhp_pkg::RHP_NPORT-1:0] io_pin_out
);
    import rhp_pkg::*;
    logic [5:0] ctrl_q;
    logic base, remote, router, ind, fc;
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            ctrl_q <= RHP_CTRL_RST;
        else if (avs_write && !avs_waitrequest && avs_address == RHP_CTRL && avs_byteenable[0])
            ctrl_q <= avs_writedata[5:0];
    end
    assign base = ctrl_q[1:0] == 2'd0;
    assign router = ctrl_q[1:0] == 2'd2;
    assign remote = ctrl_q[0];
    assign ind = !ctrl_q[RHP_C_ACT_ALT];
    assign fc = ctrl_q[RHP_C_FC_ALT];
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // One wait cycle per request
    sequence s_answer;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence
    sequence s_link_up;
        !link_detect_n;
    endsequence
    a_bus_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> s_answer)
        else $error("bus wait wrong");
    a_act_base_rx: assert property (base && ind && rx_valid |=> activity_indicator)
        else $error("base rx no pulse");
    a_act_remote_tx: assert property (remote && ind && tx_done |=> activity_indicator)
        else $error("remote tx no pulse");
    a_act_router_ev: assert property (router && ind && (rx_valid && rx_upstream ||
        tx_done && tx_downstream) |=> activity_indicator)
        else $error("router no pulse");
    a_act_alt_data: assert property (!ind && $past(ctrl_q[RHP_C_ACT_ALT])
        |-> activity_indicator == $past(diagnostic_serial_out_data))
        else $error("act alt data wrong");
    a_link_base_rx: assert property (base && rx_valid |=> s_link_up)
        else $error("base rx no link");
    a_link_sync_gain: assert property (!base && hop_sync_gain |=> s_link_up)
        else $error("no link on sync gain");
    a_link_pin_dir: assert property ($stable(ctrl_q[RHP_C_LNK_ALT])
        |-> link_pin_oe == !ctrl_q[RHP_C_LNK_ALT])
        else $error("link pin direction wrong");
    a_cts_tracks_ready: assert property (fc && $past(ctrl_q[RHP_C_FC_ALT], 3) && !sleep_mode
        && !$past(sleep_mode, 2) |-> io_pin_out[RHP_P_CTS] == !$past(host_rx_ready, 2))
        else $error("cts wrong");
    a_rts_halts_tx: assert property (fc && $past(ctrl_q[RHP_C_FC_ALT], 4)
        && $past(io_pin_in[RHP_P_RTS], 3) |-> !host_tx_allow)
        else $error("transmit not halted");
endmodule : rhp_pin_status_checker
bind rhp_pin_status rhp_pin_status_checker chk_u (.*);
`default_nettype wire

// >>> testbench/rhp_host_model.sv
// Purpose: Host side of the flow control handshake
// Assumes: Host on the block clock
// Notes: sending means host pushes data
`timescale 1ns/100ps
`default_nettype none
module rhp_host_model (
    // Clock
    input wire logic clock,
    // Flow control
    input wire logic cts_n,
    input wire logic hold,
    output logic rts_n,
    output logic sending
);
    initial {rts_n, sending} = 2'b10;
    always @(posedge clock)
    begin
        rts_n <= hold;
        sending <= !cts_n;
    end
endmodule : rhp_host_model
`default_nettype wire

// >>> testbench/rhp_pin_status_test.sv
// Purpose: Self-checking bench for the radio host pin block
// Assumes: Host model on ports four and five
// Notes: Pins resolve to the block drive where enabled
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
    $display("[FAIL] %0t %h %h", $time, g, e); end end
module rhp_pin_status_test;
    import rhp_pkg::*;
    logic clock, rst_n, avs_read, avs_write, avs_waitrequest, irq;
    logic [7:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [3:0] avs_byteenable;
    logic rx_valid, rx_upstream, tx_done, tx_downstream, hop_sync_gain, hop_tick, beacon_heard;
    logic sleep_mode, host_rx_ready, diagnostic_serial_out_data, diagnostic_serial_in, host_tx_allow, wake_req;
    logic activity_indicator, link_pin_in, link_detect_n, link_pin_oe, diagnostic_serial_in_q, hold_q;
    logic rts_n, sending;
    logic [5:0] io_pin_in, io_pin_out, io_pin_oe, io_pull_en, ext_q;
    int fail_count, tests_run, cyc, hi;
    assign io_pin_in = (io_pin_oe & io_pin_out) | (~io_pin_oe & {rts_n, ext_q[4:0]});
    assign link_pin_in = link_pin_oe ? link_detect_n : diagnostic_serial_in_q;
    rhp_pin_status dut_u (.*);
    rhp_host_model host_u (.clock(clock), .cts_n(io_pin_out[4]), .hold(hold_q), .rts_n(rts_n),
        .sending(sending));
    task complete_run;
        if (fail_count == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : complete_run
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge clock);
        while (avs_waitrequest !== 1'b0)
            @(posedge clock);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clock);
    endtask : bus
    task strobe(input logic [4:0] v);
        {rx_valid, tx_done, hop_sync_gain, hop_tick, beacon_heard} <= v;
        @(posedge clock);
        {rx_valid, tx_done, hop_sync_gain, hop_tick, beacon_heard} <= 5'h00;
        @(posedge clock);
    endtask : strobe
    task t_reset;
        repeat (2) @(posedge clock);
        `CHK({link_detect_n, io_pin_oe, io_pull_en, activity_indicator}, {1'b1, 6'h00, 6'h3F, 1'b0})
        bus(1'b1, 8'h3C, 32'h0000FFFF);
        bus(1'b0, 8'h3C, 32'h0);
        `CHK(rd, 32'h00000000)
        bus(1'b0, RHP_PULL, 32'h0);
        `CHK(rd, 32'h0000003F)
        bus(1'b0, RHP_PULSE, 32'h0);
        `CHK(rd, 32'h00000100)
    endtask : t_reset
    task t_link;
        bus(1'b1, RHP_TMO, 32'h00000014);
        bus(1'b1, RHP_IMASK, 32'h00000006);
        bus(1'b1, RHP_CTRL, 32'h00000000);
        strobe(5'h10);
        @(posedge clock);
        `CHK({link_detect_n, irq}, 2'b01)
        bus(1'b0, RHP_ISTAT, 32'h0);
        `CHK(rd[RHP_I_UP], 1'b1)
        repeat (12) @(posedge clock);
        `CHK({link_detect_n, irq}, 2'b00)
        repeat (12) @(posedge clock);
        `CHK({link_detect_n, irq}, 2'b11)
        bus(1'b1, RHP_IMASK, 32'h00000000);
        bus(1'b0, RHP_ISTAT, 32'h0);
        bus(1'b1, RHP_CTRL, 32'h00000001);
        strobe(5'h04);
        `CHK({link_detect_n, irq}, 2'b00)
        for (int i = 0; i < 99; i++)
            strobe(i == 49 ? 5'h03 : 5'h02);
        `CHK(link_detect_n, 1'b0)
        strobe(5'h02);
        `CHK(link_detect_n, 1'b1)
    endtask : t_link
    task t_ports;
        bus(1'b1, RHP_DIR, 32'h07);
        bus(1'b1, RHP_LVL, 32'h05);
        bus(1'b1, RHP_PULL, 32'h08);
        @(posedge clock);
        `CHK({io_pin_oe, io_pin_out[2:0], io_pull_en}, {6'h07, 3'h5, 6'h08})
        bus(1'b1, RHP_WAKE, 32'h08);
        bus(1'b1, RHP_SDIR, 32'h01);
        bus(1'b1, RHP_SLVL, 32'h01);
        bus(1'b1, RHP_SPULL, 32'h10);
        bus(1'b1, RHP_IMASK, 32'h08);
        sleep_mode <= 1'b1;
        repeat (3) @(posedge clock);
        `CHK({io_pin_oe, io_pin_out[0], io_pull_en}, {6'h01, 1'b1, 6'h10})
        ext_q <= 6'h08;
        hi = 0;
        repeat (10) @(posedge clock) hi += (wake_req === 1'b1);
        `CHK({hi, irq}, {32'd1, 1'b1})
        sleep_mode <= 1'b0;
        bus(1'b0, RHP_ISTAT, 32'h0);
        `CHK(rd[RHP_I_WAKE], 1'b1)
        bus(1'b1, RHP_DIR, 32'h00);
    endtask : t_ports
    task t_flow;
        bus(1'b1, RHP_CTRL, 32'h00000011);
        for (int i = 0; i < 2; i++)
        begin
            host_rx_ready <= i[0];
            hold_q <= !i[0];
            repeat (6) @(posedge clock);
            `CHK({io_pin_oe[4], io_pin_out[4], sending}, {1'b1, !i[0], i[0]})
            `CHK(host_tx_allow, i[0])
        end
    endtask : t_flow
    task t_activity;
        bus(1'b1, RHP_PULSE, 32'h00000004);
        for (int r = 0; r < 3; r++)
            for (int e = 0; e < 4; e++)
            begin
                bus(1'b1, RHP_CTRL, r);
                {rx_upstream, tx_downstream} <= {2{!e[0]}};
                {rx_valid, tx_done} <= {e < 2, e > 1};
                @(posedge clock);
                {rx_valid, tx_done} <= 2'b00;
                hi = 0;
                repeat (8) @(posedge clock) hi += (activity_indicator === 1'b1);
                `CHK(hi, (r == 0 ? e < 2 : r == 1 ? e >= 2 : !e[0]) ? 4 : 0)
            end
        tx_downstream <= 1'b1;
        strobe(5'h08);
        strobe(5'h08);
        repeat (2) @(posedge clock);
        `CHK(activity_indicator, 1'b1)
    endtask : t_activity
    task t_alt;
        bus(1'b1, RHP_CTRL, 32'h0000000C);
        for (int i = 0; i < 2; i++)
        begin
            diagnostic_serial_out_data <= i[0];
            diagnostic_serial_in_q <= i[0];
            repeat (4) @(posedge clock);
            `CHK(activity_indicator, i[0])
            `CHK({link_pin_oe, diagnostic_serial_in}, {1'b0, i[0]})
        end
    endtask : t_alt
    initial
    begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    always @(posedge clock)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fail_count++;
            complete_run();
        end
    end
    initial
    begin
        {rst_n, avs_read, avs_write, avs_address, avs_writedata} = '0;
        {rx_valid, rx_upstream, tx_done, tx_downstream, hop_sync_gain, hop_tick} = '0;
        {beacon_heard, sleep_mode, host_rx_ready, diagnostic_serial_out_data, ext_q} = '0;
        {diagnostic_serial_in_q, hold_q, avs_byteenable} = 6'h3F;
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        t_reset();
        t_link();
        t_ports();
        t_flow();
        t_activity();
        t_alt();
        complete_run();
    end
endmodule : rhp_pin_status_test
`default_nettype wire
